// ---- design/ddbo_beat_order.sv ----
`timescale 1ns/1ps
module ddbo_beat_order
  import ddbo_pkg::*;
(
  // Burst setup
  input wire logic [2:0] i_start,
  input wire logic i_interleave,
  input wire logic i_write,
  // Beat
  input wire logic [2:0] i_beat,
  output logic [2:0] o_col
);
  always_comb
  begin
    // (RULE_05) writes ignore start
    if (i_write)
      o_col = i_beat;
    // (RULE_04) beat XOR start
    else if (i_interleave)
      o_col = i_start ^ i_beat;
    // (RULE_03) wrap within each half
    else
      o_col = {i_start[2] ^ i_beat[2], 2'(i_start[1:0] + i_beat[1:0])};
  end
endmodule

// ---- design/ddbo_pkg.sv ----
package ddbo_pkg;
  // Mode register selection by bank group and bank address
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE = 3'h1;
  localparam logic [2:0] MR_FOUR = 3'h4;
  // Field positions on the address pins
  localparam int BL_LSB = 0;
  localparam int BURST_TYPE_BIT = 3;
  localparam int DLL_RESET_BIT = 8;
  localparam int DLL_ENABLE_BIT = 0;
  localparam int SR_ABORT_BIT = 9;
  localparam int CHOP_SEL_BIT = 12;
  // Burst length option encodings
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_PER_CMD = 2'h1;
  localparam logic [1:0] BL_FIXED_CHOP = 2'h2;
  // Reset values
  localparam logic [1:0] BL_RESET = 2'h0;
  localparam logic DLL_ON_RESET = 1'b1;
  // Timing counts in clock cycles
  localparam int WR_START_CYC = 8;
  localparam int CHOP_PULL_IN_CYC = 2;
  localparam int REFRESH_CYC = 16;
  localparam int SR_REFRESH_PERIOD_CYC = 64;
  localparam int DLL_LOCK_CYC = 768;
  // Register bus byte addresses
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_REF_COUNT = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h8;
  localparam int CTRL_CRC_BIT = 0;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bg;
    logic [1:0] ba;
    logic [13:0] addr;
  } ddbo_pins_t;
endpackage

// ---- design/ddbo_top.sv ----
`timescale 1ns/1ps
// Operation
// (RULE_01) Burst type from mode zero bit 3, length option from bits 1:0.
// (RULE_02) Per-command mode: chop select bit picks four-beat chop or eight beats.
// (RULE_03) Sequential reads start at low column bits, wrap in each half.
// (RULE_04) Interleaved reads order words as beat XOR start column.
// (RULE_05) Eight-beat writes ignore low column bits, store in order 0..7.
// (RULE_06) Fixed chop mode starts internal write two clocks earlier.
// (RULE_07) Per-command chop starts internal write at eight-beat time.
// (RULE_08) Write CRC with fixed eight beats uses start column zero only.
// (RULE_09) Mode one bit 0 low disables DLL until written high.
// (RULE_10) Controller precharges, meets timings, parks termination before DLL off.
// (RULE_11) Controller waits update delay, self refresh, clock times around change.
// (RULE_12) Controller holds clock enable high, termination low after exit.
// (RULE_13) Controller waits full exit delay before normal commands.
// (RULE_14) After fast exit only calibration and latency mode writes allowed.
// (RULE_15) Abort enabled: exit aborts refresh, counter not incremented.
// (RULE_16) Controller issues one extra refresh before next self refresh.
// (RULE_17) Controller reprograms latencies after exit, waits update delay.
// (RULE_18) Controller holds clock enable high until lock after DLL reset.
// (RULE_19) Controller waits exit delay then writes mode one bit 0 high.
// (RULE_20) Mode zero bit 8 high starts DLL reset and relock.
// (RULE_21) Controller may calibrate during lock after update delay.
// (RULE_22) Controller waits lock time and calibration time after DLL reset.
module ddbo_top
  import ddbo_pkg::*;
#(
  parameter int WR_CYC = WR_START_CYC,
  parameter int LOCK_CYC = DLL_LOCK_CYC
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Command and address pins
  input wire ddbo_pins_t i_pins,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Burst column stream
  output logic [2:0] o_col,
  output logic o_col_v,
  output logic o_col_wr,
  output logic o_wr_int_start,
  // Device state
  output logic o_dll_on,
  output logic o_dll_locked,
  output logic o_self_refresh
);
  ddbo_pins_t pin_s1_q;
  ddbo_pins_t pin_q;
  logic cke_prev_q;
  logic [1:0] bl_q;
  logic interleave_q;
  logic sr_abort_q;
  logic crc_q;
  logic [9:0] lock_cnt_q;
  logic [3:0] wr_cnt_q;
  logic burst_q;
  logic chop_q;
  logic wr_q;
  logic [2:0] start_q;
  logic [2:0] beat_q;
  logic [2:0] col_d;
  logic [4:0] ref_cnt_q;
  logic ref_busy_q;
  logic [6:0] sr_tick_q;
  logic [15:0] ref_total_q;
  logic [2:0] mr_sel;
  logic cmd_v, cmd_mrs, cmd_ref, cmd_rd, cmd_wr, cmd_sre, cmd_srx;
  logic chop_cmd;

  // Pins cross in through two flops
  always_ff @(posedge i_sys_clk)
  begin
    pin_s1_q <= i_pins;
    pin_q <= pin_s1_q;
    cke_prev_q <= pin_q.cke;
  end

  assign mr_sel = {pin_q.bg, pin_q.ba};
  assign cmd_v = cke_prev_q && !pin_q.cs_n && pin_q.act_n && !o_self_refresh;
  assign cmd_mrs = cmd_v && pin_q.cke && !pin_q.ras_n && !pin_q.cas_n && !pin_q.we_n;
  assign cmd_ref = cmd_v && !pin_q.ras_n && !pin_q.cas_n && pin_q.we_n;
  assign cmd_sre = cmd_ref && !pin_q.cke;
  assign cmd_rd = cmd_v && pin_q.cke && pin_q.ras_n && !pin_q.cas_n && pin_q.we_n;
  assign cmd_wr = cmd_v && pin_q.cke && pin_q.ras_n && !pin_q.cas_n && !pin_q.we_n;
  assign cmd_srx = o_self_refresh && !cke_prev_q && pin_q.cke;
  // (RULE_02) chop chosen per command
  assign chop_cmd = (bl_q == BL_FIXED_CHOP) ||
                    ((bl_q == BL_PER_CMD) && !pin_q.addr[CHOP_SEL_BIT]);

  // (RULE_01) burst mode fields
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      bl_q <= BL_RESET;
      interleave_q <= 1'b0;
      sr_abort_q <= 1'b0;
    end
    else if (cmd_mrs && mr_sel == MR_ZERO)
    begin
      bl_q <= pin_q.addr[BL_LSB +: 2];
      interleave_q <= pin_q.addr[BURST_TYPE_BIT];
    end
    else if (cmd_mrs && mr_sel == MR_FOUR)
      sr_abort_q <= pin_q.addr[SR_ABORT_BIT];
  end

  // (RULE_09) DLL enable bit
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_dll_on <= DLL_ON_RESET;
    else if (cmd_mrs && mr_sel == MR_ONE)
      o_dll_on <= pin_q.addr[DLL_ENABLE_BIT];
  end

  // (RULE_20) DLL reset and relock
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      lock_cnt_q <= '0;
      o_dll_locked <= 1'b0;
    end
    else if (cmd_mrs && mr_sel == MR_ONE && !pin_q.addr[DLL_ENABLE_BIT])
    begin
      lock_cnt_q <= '0;
      o_dll_locked <= 1'b0;
    end
    else if (cmd_mrs && mr_sel == MR_ZERO && pin_q.addr[DLL_RESET_BIT] && o_dll_on)
    begin
      lock_cnt_q <= 10'(LOCK_CYC);
      o_dll_locked <= 1'b0;
    end
    else if (lock_cnt_q != '0)
    begin
      lock_cnt_q <= lock_cnt_q - 10'h1;
      o_dll_locked <= (lock_cnt_q == 10'h1);
    end
  end

  // Burst column engine, one beat per clock
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      burst_q <= 1'b0;
      beat_q <= '0;
      start_q <= '0;
      chop_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else if (cmd_rd || cmd_wr)
    begin
      burst_q <= 1'b1;
      beat_q <= '0;
      // (RULE_08) CRC writes forced to start zero
      start_q <= (cmd_wr && crc_q && bl_q == BL_FIXED8) ? 3'h0 : pin_q.addr[2:0];
      chop_q <= chop_cmd;
      wr_q <= cmd_wr;
    end
    else if (burst_q)
    begin
      beat_q <= beat_q + 3'h1;
      if (beat_q == 3'h7 || (chop_q && beat_q == 3'h3))
        burst_q <= 1'b0;
    end
  end

  // Writes linear; chop writes stay in the half picked by start bit 2
  ddbo_beat_order u_order (
    .i_start(start_q),
    .i_interleave(interleave_q),
    .i_write(wr_q),
    .i_beat(wr_q && chop_q ? {start_q[2], beat_q[1:0]} : beat_q),
    .o_col(col_d)
  );

  // (RULE_03) column stream out
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_col <= '0;
      o_col_v <= 1'b0;
      o_col_wr <= 1'b0;
    end
    else
    begin
      o_col <= col_d;
      o_col_v <= burst_q;
      o_col_wr <= wr_q;
    end
  end

  // (RULE_06) fixed chop pulls internal write in
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      wr_cnt_q <= '0;
      o_wr_int_start <= 1'b0;
    end
    else
    begin
      if (cmd_wr)
        // (RULE_07) per-command chop keeps full delay
        wr_cnt_q <= (bl_q == BL_FIXED_CHOP) ? 4'(WR_CYC - CHOP_PULL_IN_CYC) : 4'(WR_CYC);
      else if (wr_cnt_q != '0)
        wr_cnt_q <= wr_cnt_q - 4'h1;
      o_wr_int_start <= !cmd_wr && (wr_cnt_q == 4'h1);
    end
  end

  // Self refresh state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_self_refresh <= 1'b0;
    else if (cmd_sre)
      o_self_refresh <= 1'b1;
    else if (cmd_srx)
      o_self_refresh <= 1'b0;
  end

  // Refresh engine and counter
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ref_busy_q <= 1'b0;
      ref_cnt_q <= '0;
      sr_tick_q <= '0;
      ref_total_q <= '0;
    end
    else if (cmd_srx && sr_abort_q)
    begin
      // (RULE_15) abort drops refresh uncounted
      ref_busy_q <= 1'b0;
      ref_cnt_q <= '0;
      sr_tick_q <= '0;
    end
    else
    begin
      sr_tick_q <= o_self_refresh ? sr_tick_q + 7'h1 : 7'h0;
      if ((cmd_ref || (o_self_refresh && sr_tick_q == 7'(SR_REFRESH_PERIOD_CYC - 1)))
          && !ref_busy_q)
      begin
        ref_busy_q <= 1'b1;
        ref_cnt_q <= 5'(REFRESH_CYC);
      end
      else if (ref_busy_q)
      begin
        ref_cnt_q <= ref_cnt_q - 5'h1;
        if (ref_cnt_q == 5'h1)
        begin
          ref_busy_q <= 1'b0;
          ref_total_q <= ref_total_q + 16'h1;
        end
      end
    end
  end

  // Register port
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      crc_q <= 1'b0;
    else if (i_reg_wr && i_reg_addr == REG_CONTROL)
      crc_q <= i_reg_wdata[CTRL_CRC_BIT];
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_reg_rdata <= '0;
    else if (i_reg_rd)
      case (i_reg_addr)
        REG_STATUS: o_reg_rdata <= {25'h0, o_dll_locked, o_dll_on, o_self_refresh,
                                    sr_abort_q, interleave_q, bl_q};
        REG_REF_COUNT: o_reg_rdata <= {16'h0, ref_total_q};
        REG_CONTROL: o_reg_rdata <= {31'h0, crc_q};
        default: o_reg_rdata <= '0;
      endcase
    else
      o_reg_rdata <= '0;
  end

  mr_type_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_01
    cmd_mrs && mr_sel == MR_ZERO |=> interleave_q == $past(pin_q.addr[BURST_TYPE_BIT])
    && bl_q == $past(pin_q.addr[1:0])) else $error("burst mode not taken");
  chop_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_02
    burst_q && chop_q |-> beat_q <= 3'h3) else $error("chop burst too long");
  seq_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_03
    $past(burst_q) && !$past(wr_q) && !$past(interleave_q) |-> o_col ==
    {$past(start_q[2]) ^ $past(beat_q[2]), 2'($past(start_q[1:0]) + $past(beat_q[1:0]))})
    else $error("sequential order wrong");
  ileave_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_04
    $past(burst_q) && !$past(wr_q) && $past(interleave_q) |->
    o_col == ($past(start_q) ^ $past(beat_q))) else $error("interleaved order wrong");
  write_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_05
    $past(burst_q) && $past(wr_q) && !$past(chop_q) |-> o_col == $past(beat_q))
    else $error("write order not linear");
  chop_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_06
    cmd_wr && bl_q == BL_FIXED_CHOP ##1 !cmd_wr [*6] |=> o_wr_int_start)
    else $error("fixed chop write start late");
  otf_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_07
    cmd_wr && bl_q != BL_FIXED_CHOP ##1 !cmd_wr [*8] |=> o_wr_int_start)
    else $error("write start not at full delay");
  crc_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_08
    cmd_wr && crc_q && bl_q == BL_FIXED8 |=> start_q == 3'h0) else $error("crc start");
  dll_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_09
    cmd_mrs && mr_sel == MR_ONE && !pin_q.addr[DLL_ENABLE_BIT] |=> !o_dll_on && !o_dll_locked)
    else $error("DLL not disabled");
  abort_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_15
    cmd_srx && sr_abort_q |=> $stable(ref_total_q) && !ref_busy_q)
    else $error("aborted refresh counted");
  relock_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // RULE_20
    cmd_mrs && mr_sel == MR_ZERO && pin_q.addr[DLL_RESET_BIT] && o_dll_on
    |=> !o_dll_locked [*8]) else $error("DLL locked too soon");

  rd_burst_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) cmd_rd ##9 !burst_q);
  sr_cycle_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) cmd_sre ##[1:200] cmd_srx);
  relock_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_dll_locked));
endmodule

// ---- verification/ddbo_burst_order_dll_switch_test.sv ----
`timescale 1ns/1ps
module ddbo_burst_order_dll_switch_test;
  import ddbo_pkg::*;
  localparam int LOCK = 20;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  ddbo_pins_t pins;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] o_reg_rdata;
  logic [2:0] o_col;
  logic o_col_v;
  logic o_col_wr;
  logic o_wr_int_start;
  logic o_dll_on;
  logic o_dll_locked;
  logic o_self_refresh;
  int failures = 0;
  int comparisons = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  ddbo_ctrl_model u_ctrl (.i_sys_clk(i_sys_clk), .o_pins(pins));

  ddbo_top #(.LOCK_CYC(LOCK)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_pins(pins),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_col(o_col), .o_col_v(o_col_v), .o_col_wr(o_col_wr),
    .o_wr_int_start(o_wr_int_start), .o_dll_on(o_dll_on), .o_dll_locked(o_dll_locked),
    .o_self_refresh(o_self_refresh)
  );

  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(o_reg_rdata, e);
  endtask

  // Mode 0 sequential, 1 interleaved, 2 in order, 3 in order within start half
  function automatic logic [2:0] exp_col(input logic [2:0] s, input int m, input int b);
    logic [2:0] bb;
    bb = 3'(b);
    case (m)
      0: exp_col = ((s ^ bb) & 3'h4) | ((s + bb) & 3'h3);
      1: exp_col = s ^ bb;
      2: exp_col = bb;
      default: exp_col = (s & 3'h4) | bb;
    endcase
  endfunction

  // Beat index of internal write start counted from the first beat; 99 means none
  task automatic burst(input logic wr, input logic [13:0] a, input int m, input int n,
                       input int off);
    int k;
    int nb;
    int ws;
    nb = 0;
    ws = 99;
    u_ctrl.issue(wr ? 3'h4 : 3'h5, 3'h0, a);
    for (k = 0; k < 20 && o_col_v !== 1'b1; k++)
    begin
      @(posedge i_sys_clk);
      #1;
    end
    for (k = 0; k < 12; k++)
    begin
      if (o_col_v === 1'b1 && nb < 8)
      begin
        check(32'(o_col), 32'(exp_col(a[2:0], m, nb)));
        check(32'(o_col_wr), 32'(wr));
        nb++;
      end
      if (o_wr_int_start === 1'b1)
        ws = k;
      @(posedge i_sys_clk);
      #1;
    end
    check(32'(nb), 32'(n));
    check(32'(ws), 32'(off));
  endtask

  task automatic t_reads();
    for (int t = 0; t < 2; t++)
    begin
      u_ctrl.mode_write(MR_ZERO, 14'(t << BURST_TYPE_BIT));
      for (int s = 0; s < 8; s++)
        burst(1'b0, 14'(s), t, 8, 99);
    end
  endtask

  task automatic t_writes();
    u_ctrl.mode_write(MR_ZERO, 14'h0000);
    burst(1'b1, 14'h0005, 2, 8, 7);
    u_ctrl.mode_write(MR_ZERO, 14'h0008);
    burst(1'b1, 14'h0006, 2, 8, 7);
    u_ctrl.mode_write(MR_ZERO, 14'h0002);
    burst(1'b1, 14'h0005, 3, 4, 5);
    u_ctrl.mode_write(MR_ZERO, 14'h0001);
    burst(1'b1, 14'h1005, 2, 8, 7);
    burst(1'b1, 14'h0005, 3, 4, 7);
    burst(1'b0, 14'h0001, 0, 4, 99);
  endtask

  task automatic t_crc();
    reg_write(REG_CONTROL, 32'h1);
    reg_read(REG_CONTROL, 32'h1);
    u_ctrl.mode_write(MR_ZERO, 14'h0000);
    burst(1'b1, 14'h0003, 2, 8, 7);
    reg_read(REG_STATUS, 32'h20);
    reg_read(4'hc, 32'h0);
  endtask

  task automatic t_dll();
    int n;
    u_ctrl.mode_write(MR_FOUR, 14'h0200);
    u_ctrl.mode_write(MR_ONE, 14'h0000);
    check(32'(o_dll_on), 32'h0);
    check(32'(o_dll_locked), 32'h0);
    reg_read(REG_STATUS, 32'h08);
    u_ctrl.sr_enter();
    check(32'(o_self_refresh), 32'h1);
    reg_read(REG_STATUS, 32'h18);
    u_ctrl.sr_exit();
    check(32'(o_self_refresh), 32'h0);
    check(32'(o_dll_on), 32'h0);
    u_ctrl.mode_write(MR_ONE, 14'h0001);
    check(32'(o_dll_on), 32'h1);
    u_ctrl.issue(3'h0, MR_ZERO, 14'h0100);
    for (n = 0; n < 60 && o_dll_locked !== 1'b1; n++)
    begin
      @(posedge i_sys_clk);
      #1;
    end
    check(32'(n >= LOCK - 2 && n <= LOCK + 6), 32'h1);
    reg_read(REG_STATUS, 32'h68);
    reg_read(REG_REF_COUNT, 32'h1);
    u_ctrl.mode_write(MR_FOUR, 14'h0000);
    u_ctrl.sr_enter();
    u_ctrl.sr_exit();
    reg_read(REG_REF_COUNT, 32'h3);
  endtask

  initial
  begin
    #400000;
    failures++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reads();
    t_writes();
    t_crc();
    t_dll();
    test_done();
  end
endmodule

// ---- verification/ddbo_ctrl_model.sv ----
`timescale 1ns/1ps
module ddbo_ctrl_model
  import ddbo_pkg::*;
#(
  parameter int XS_CYC = 12,
  parameter int MOD_CYC = 8
)
(
  // Clock
  input wire logic i_sys_clk,
  // Command and address pins
  output ddbo_pins_t o_pins
);
  initial
  begin
    o_pins = '0;
    o_pins.cke = 1'b1;
    o_pins.cs_n = 1'b1;
    o_pins.act_n = 1'b1;
  end
  // Deselected: address lines show no stale value
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge i_sys_clk);
      o_pins.cs_n <= 1'b1;
      o_pins.addr <= ~o_pins.addr;
    end
  endtask
  task automatic issue(input logic [2:0] cmd, input logic [2:0] sel, input logic [13:0] a);
    @(posedge i_sys_clk);
    o_pins.cs_n <= 1'b0;
    {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= cmd;
    {o_pins.bg, o_pins.ba} <= sel;
    o_pins.addr <= a;
    idle(1);
  endtask
  task automatic mode_write(input logic [2:0] sel, input logic [13:0] a);
    issue(3'h0, sel, a);
    idle(MOD_CYC);
  endtask
  // idle, no open banks, entry clock time
  task automatic sr_enter();
    @(posedge i_sys_clk);
    o_pins.cs_n <= 1'b0;
    {o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= 3'h1;
    o_pins.cke <= 1'b0;
    idle(XS_CYC);
  endtask
  // clock enable held, exit wait, extra refresh
  task automatic sr_exit();
    @(posedge i_sys_clk);
    o_pins.cke <= 1'b1;
    idle(XS_CYC);
    issue(3'h1, 3'h0, 14'h0);
    idle(20);
  endtask
endmodule
